/* File: src/pes_sampler.sv */
// Precise event sampler: arm on overflow, capture at retirement, buffer samples
// What this block does
// - Precise counter overflow arms, not captures
// - Next armed event records sample, signals done
// - Sample holds IP and register state
// - Stored IP is the following instruction
// - Buffer samples; interrupt only when full
// - Events detected at retirement, except retirement stall (no ret_valid needed)
// - Memory and execution event classes
// - Load latency samples store latency, source
// - Any-port stall counts whole core
// - Port 0,1,5 stall counted per thread
// - Retirement stall per thread, captures IP
// - Interrupt masking never delays capture
// - Edge counting needs nonzero threshold
`timescale 1ns/1ns
`default_nettype none
module pes_sampler (
    input wire logic clk_sys,                              // System clock, 25 MHz
    input wire logic rstn,                                 // Async reset, active low
    input wire logic clk_en,                               // Freezes state when low
    input wire logic cfg_precise,                          // Precise sampling on
    input wire pes_pkg::pes_event_e cfg_event,             // Selected event
    input wire logic cfg_thread,                           // Thread being sampled
    input wire logic [pes_pkg::PES_THR_W-1:0] cfg_thresh,  // Counter threshold
    input wire logic cfg_edge,                             // Edge option
    input wire logic cfg_invert,                           // Invert option
    input wire logic [pes_pkg::PES_LAT_W-1:0] cfg_lat_min, // Latency event floor
    input wire logic cfg_load,                             // Load counter preset
    input wire logic [pes_pkg::PES_CNT_W-1:0] cfg_preset,  // Counter preset
    input wire logic ret_valid,                            // Instruction retires
    input wire logic ret_thread,                           // Its thread
    input wire logic ret_is_load,                          // It holds a load
    input wire logic ret_is_store,                         // It holds a store
    input wire logic ret_is_branch,                        // It is a branch
    input wire logic [pes_pkg::PES_IP_W-1:0] ret_next_ip,  // IP after it
    input wire logic [pes_pkg::PES_REGS_W-1:0] ret_regs,   // Registers after it
    input wire logic [pes_pkg::PES_LAT_W-1:0] ret_lat,     // Load-to-use latency
    input wire logic [pes_pkg::PES_SRC_W-1:0] ret_src,     // Data source of load
    input wire logic [1:0] ret_active,                     // Uops retire, per thread
    input wire logic [1:0] disp_any,                       // Uop on any port, per thread
    input wire logic [1:0] disp_alu,                       // Uop on port 0,1,5, per thread
    input wire logic smp_rd_req,                           // Pop one sample
    output logic smp_valid,                                // Sample words valid, pulse
    output logic [pes_pkg::PES_IP_W-1:0] smp_ip,           // Sample IP
    output logic [pes_pkg::PES_REGS_W-1:0] smp_regs,       // Sample registers
    output logic [pes_pkg::PES_LAT_W-1:0] smp_lat,         // Sample latency
    output logic [pes_pkg::PES_SRC_W-1:0] smp_src,         // Sample data source
    output logic [2:0] smp_count,                          // Samples held
    output logic sample_done,                              // Capture done, pulse
    output logic monitor_overflow_interrupt,               // Buffer full
    output logic armed,                                    // Capture armed
    output logic [pes_pkg::PES_CNT_W-1:0] ev_value,        // Precise counter value
    output logic [pes_pkg::PES_CNT_W-1:0] core_stall_count,  // Core any-port stalls
    output logic [pes_pkg::PES_CNT_W-1:0] thread_alu_port_stall_count0, // Thread 0
    output logic [pes_pkg::PES_CNT_W-1:0] thread_alu_port_stall_count1, // Thread 1
    output logic [pes_pkg::PES_CNT_W-1:0] ret_stall_count0, // Thread 0 retire stalls
    output logic [pes_pkg::PES_CNT_W-1:0] ret_stall_count1  // Thread 1 retire stalls
);
    import pes_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic armed_ff;
    logic done_ff;
    logic intr_ff;
    logic rd_valid_ff;
    logic [2:0] occ_ff;
    logic [PES_PTR_W-1:0] wr_ptr_ff;
    logic [PES_PTR_W-1:0] rd_ptr_ff;
    logic [PES_IP_W-1:0] buf_ip [PES_BUF_DEPTH];
    logic [PES_REGS_W-1:0] buf_regs [PES_BUF_DEPTH];
    logic [PES_LAT_W-1:0] buf_lat [PES_BUF_DEPTH];
    logic [PES_SRC_W-1:0] buf_src [PES_BUF_DEPTH];
    logic [PES_IP_W-1:0] out_ip_ff;
    logic [PES_REGS_W-1:0] out_regs_ff;
    logic [PES_LAT_W-1:0] out_lat_ff;
    logic [PES_SRC_W-1:0] out_src_ff;
    logic [PES_CNT_W-1:0] core_stall_ff;
    logic [PES_CNT_W-1:0] alu_stall_ff [2];
    logic [PES_CNT_W-1:0] ret_stall_ff [2];
    wire own_ret;
    wire ev_hit;
    wire ctr_ovf;
    wire capture;
    wire pop;
    wire buf_full;
    wire buf_empty;
    wire nxt_armed;
    wire [2:0] nxt_occ;

    // Saturation-free increment used by every stall counter
    function automatic logic [PES_CNT_W-1:0] bump(input logic [PES_CNT_W-1:0] v,
                                                  input logic hit);
        bump = hit ? v + 32'h1 : v;
    endfunction : bump

    ////////////////////////////////////////////////////////////////////////////////
    // Event selection, all taken from the retirement stream
    // retirement-only event sources
    assign own_ret = ret_valid & (ret_thread == cfg_thread);
    assign ev_hit = (cfg_event == PES_EV_LOADS) ? own_ret & ret_is_load :
                    (cfg_event == PES_EV_STORES) ? own_ret & ret_is_store :
                    (cfg_event == PES_EV_INSTS) ? own_ret :
                    (cfg_event == PES_EV_BRANCHES) ? own_ret & ret_is_branch :
                    (cfg_event == PES_EV_LOAD_LAT) ?
                        own_ret & ret_is_load & (ret_lat >= cfg_lat_min) :
                    (cfg_event == PES_EV_RET_STALL) ? ~ret_active[cfg_thread] :
                    1'b0;

    // Precise general counter
    pes_counter u_ctr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clk_en(clk_en),
        .ev_count({2'h0, ev_hit}),
        .thresh(cfg_thresh),
        .edge_en(cfg_edge),
        .invert(cfg_invert),
        .load(cfg_load),
        .preset(cfg_preset),
        .value(ev_value),
        .ovf(ctr_ovf)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Arming and capture decisions
    assign buf_full = (occ_ff == PES_BUF_FULL);
    assign buf_empty = (occ_ff == PES_OCC_RST);
    assign capture = armed_ff & ev_hit & cfg_precise & ~buf_full;
    assign pop = smp_rd_req & ~buf_empty;
    assign nxt_armed = (armed_ff & ~capture) | (ctr_ovf & cfg_precise);
    assign nxt_occ = occ_ff + {2'h0, capture} - {2'h0, pop};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            armed_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (clk_en) begin
            armed_ff <= nxt_armed;
            done_ff <= capture;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample buffer
    // IP and register state stored
    always_ff @(posedge clk_sys) begin
        if (clk_en && capture) begin
            buf_ip[wr_ptr_ff] <= ret_next_ip;
            buf_regs[wr_ptr_ff] <= ret_regs;
            buf_lat[wr_ptr_ff] <= ret_lat;
            buf_src[wr_ptr_ff] <= ret_src;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_ff <= PES_PTR_RST;
            rd_ptr_ff <= PES_PTR_RST;
            occ_ff <= PES_OCC_RST;
            intr_ff <= 1'b0;
        end else if (clk_en) begin
            wr_ptr_ff <= wr_ptr_ff + PES_PTR_W'(capture);
            rd_ptr_ff <= rd_ptr_ff + PES_PTR_W'(pop);
            occ_ff <= nxt_occ;
            intr_ff <= (nxt_occ == PES_BUF_FULL);
        end
    end

    // Read-out registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_valid_ff <= 1'b0;
            out_ip_ff <= '0;
            out_regs_ff <= '0;
            out_lat_ff <= '0;
            out_src_ff <= '0;
        end else if (clk_en) begin
            rd_valid_ff <= pop;
            if (pop) begin
                out_ip_ff <= buf_ip[rd_ptr_ff];
                out_regs_ff <= buf_regs[rd_ptr_ff];
                out_lat_ff <= buf_lat[rd_ptr_ff];
                out_src_ff <= buf_src[rd_ptr_ff];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stall-cycle counters
    // core-wide any-port stalls, per-thread ALU-port and retirement stalls
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            core_stall_ff <= PES_CNT_RST;
            alu_stall_ff[0] <= PES_CNT_RST;
            alu_stall_ff[1] <= PES_CNT_RST;
            ret_stall_ff[0] <= PES_CNT_RST;
            ret_stall_ff[1] <= PES_CNT_RST;
        end else if (clk_en) begin
            core_stall_ff <= bump(core_stall_ff, disp_any == 2'h0);
            alu_stall_ff[0] <= bump(alu_stall_ff[0], ~disp_alu[0]);
            alu_stall_ff[1] <= bump(alu_stall_ff[1], ~disp_alu[1]);
            ret_stall_ff[0] <= bump(ret_stall_ff[0], ~ret_active[0]);
            ret_stall_ff[1] <= bump(ret_stall_ff[1], ~ret_active[1]);
        end
    end

    // Output wiring, all from flip-flops
    assign smp_valid = rd_valid_ff;
    assign smp_ip = out_ip_ff;
    assign smp_regs = out_regs_ff;
    assign smp_lat = out_lat_ff;
    assign smp_src = out_src_ff;
    assign smp_count = occ_ff;
    assign sample_done = done_ff;
    assign monitor_overflow_interrupt = intr_ff;
    assign armed = armed_ff;
    assign core_stall_count = core_stall_ff;
    assign thread_alu_port_stall_count0 = alu_stall_ff[0];
    assign thread_alu_port_stall_count1 = alu_stall_ff[1];
    assign ret_stall_count0 = ret_stall_ff[0];
    assign ret_stall_count1 = ret_stall_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_arm_on_ovf;
        clk_en && ctr_ovf && cfg_precise |=> armed_ff;
    endproperty
    a_arm_on_ovf: assert property (p_arm_on_ovf) else $error("overflow did not arm");

    property p_no_capture_unarmed;
        clk_en && !armed_ff |=> !done_ff;
    endproperty
    a_no_capture_unarmed: assert property (p_no_capture_unarmed) else $error("unarmed capture");

    property p_done_after_capture;
        clk_en && capture |=> done_ff ##1 (!clk_en || !done_ff || $past(capture));
    endproperty
    a_done_after_capture: assert property (p_done_after_capture) else $error("no done pulse");

    property p_disarm;
        clk_en && capture && !ctr_ovf |=> !armed_ff;
    endproperty
    a_disarm: assert property (p_disarm) else $error("arm kept after capture");

    property p_ip_stored;
        clk_en && capture |=> buf_ip[$past(wr_ptr_ff)] == $past(ret_next_ip);
    endproperty
    a_ip_stored: assert property (p_ip_stored) else $error("wrong sample IP");

    property p_lat_stored;
        clk_en && capture |=> buf_lat[$past(wr_ptr_ff)] == $past(ret_lat)
            && buf_src[$past(wr_ptr_ff)] == $past(ret_src);
    endproperty
    a_lat_stored: assert property (p_lat_stored) else $error("wrong latency or source");

    property p_regs_stored;
        clk_en && capture |=> buf_regs[$past(wr_ptr_ff)] == $past(ret_regs);
    endproperty
    a_regs_stored: assert property (p_regs_stored) else $error("wrong sample registers");

    property p_capture_unmasked;
        clk_en && armed_ff && ev_hit && cfg_precise && !buf_full |=> done_ff;
    endproperty
    a_capture_unmasked: assert property (p_capture_unmasked) else $error("capture held back");

    property p_intr_full;
        intr_ff |-> occ_ff == PES_BUF_FULL;
    endproperty
    a_intr_full: assert property (p_intr_full) else $error("interrupt before full");

    property p_full_raises;
        clk_en && occ_ff == 3'h3 && capture && !pop |=> intr_ff;
    endproperty
    a_full_raises: assert property (p_full_raises) else $error("full without interrupt");

    property p_retire_only;
        capture |-> ret_valid || cfg_event == PES_EV_RET_STALL;
    endproperty
    a_retire_only: assert property (p_retire_only) else $error("capture off retirement");

    property p_core_stall;
        clk_en && disp_any == 2'h0 |=> core_stall_ff == $past(core_stall_ff) + 32'h1;
    endproperty
    a_core_stall: assert property (p_core_stall) else $error("core stall not counted");

    property p_alu_stall;
        clk_en && disp_alu == 2'h2 |=> alu_stall_ff[0] == $past(alu_stall_ff[0]) + 32'h1
            && alu_stall_ff[1] == $past(alu_stall_ff[1]);
    endproperty
    a_alu_stall: assert property (p_alu_stall) else $error("thread stall wrong");
endmodule : pes_sampler
`default_nettype wire

/* File: src/pes_pkg.sv */
// Shared constants and types for the precise event sampler
package pes_pkg;
    // Data widths of the retirement stream and of a sample
    localparam int PES_IP_W = 32;
    localparam int PES_REG_N = 16;
    localparam int PES_REG_W = 32;
    localparam int PES_REGS_W = PES_REG_N * PES_REG_W;
    localparam int PES_LAT_W = 16;
    localparam int PES_SRC_W = 4;
    localparam int PES_CNT_W = 32;
    localparam int PES_THR_W = 8;
    // Sample buffer
    localparam int PES_BUF_DEPTH = 4;
    localparam int PES_PTR_W = 2;
    localparam logic [2:0] PES_BUF_FULL = 3'h4;
    // Values after reset
    localparam logic [PES_CNT_W-1:0] PES_CNT_RST = 32'h0;
    localparam logic [2:0] PES_OCC_RST = 3'h0;
    localparam logic [PES_PTR_W-1:0] PES_PTR_RST = 2'h0;

    // Event that the precise counter watches
    typedef enum logic [2:0] {
        PES_EV_LOADS,
        PES_EV_STORES,
        PES_EV_INSTS,
        PES_EV_BRANCHES,
        PES_EV_LOAD_LAT,
        PES_EV_RET_STALL
    } pes_event_e;
endpackage : pes_pkg

/* File: src/pes_counter.sv */
// General performance counter with threshold, invert and edge options
`timescale 1ns/1ns
`default_nettype none
module pes_counter (
    input wire logic clk_sys,                            // System clock
    input wire logic rstn,                               // Async reset, active low
    input wire logic clk_en,                             // Freezes state when low
    input wire logic [2:0] ev_count,                     // Event count this cycle
    input wire logic [pes_pkg::PES_THR_W-1:0] thresh,    // Threshold, zero is off
    input wire logic edge_en,                            // Count rising edges only
    input wire logic invert,                             // Invert threshold compare
    input wire logic load,                               // Load the preset value
    input wire logic [pes_pkg::PES_CNT_W-1:0] preset,    // Start value
    output logic [pes_pkg::PES_CNT_W-1:0] value,         // Current count
    output logic ovf                                     // One-cycle wrap pulse
);
    import pes_pkg::*;

    logic [PES_CNT_W-1:0] cnt_ff;
    logic prev_ff;
    logic ovf_ff;
    wire thr_on;
    wire cmp_hit;
    wire lvl;
    wire inc_one;
    wire [PES_CNT_W:0] add;
    wire [PES_CNT_W:0] sum;

    // Threshold compare and edge detect
    assign thr_on = (thresh != '0);
    assign cmp_hit = (({5'h0, ev_count}) >= thresh) ^ invert;
    assign lvl = thr_on & cmp_hit;
    assign inc_one = edge_en ? (lvl & ~prev_ff) : lvl;
    assign add = thr_on ? {{PES_CNT_W{1'b0}}, inc_one} : {30'h0, ev_count};
    assign sum = {1'b0, cnt_ff} + add;

    // Count register and wrap pulse
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= PES_CNT_RST;
            prev_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else if (clk_en) begin
            cnt_ff <= load ? preset : sum[PES_CNT_W-1:0];
            prev_ff <= lvl;
            ovf_ff <= ~load & sum[PES_CNT_W];
        end
    end

    assign value = cnt_ff;
    assign ovf = ovf_ff;
endmodule : pes_counter
`default_nettype wire

/* File: tb/pes_ret_model.sv */
// Retirement pipeline model that feeds the sampler's event inputs
`timescale 1ns/1ns
`default_nettype none
module pes_ret_model (
    input wire logic clk_sys,                          // System clock
    output logic ret_valid,                            // Retire strobe
    output logic ret_thread,                           // Retiring thread
    output logic ret_is_load,                          // Load flag
    output logic ret_is_store,                         // Store flag
    output logic ret_is_branch,                        // Branch flag
    output logic [pes_pkg::PES_IP_W-1:0] ret_next_ip,  // Following IP
    output logic [pes_pkg::PES_REGS_W-1:0] ret_regs,   // Register state
    output logic [pes_pkg::PES_LAT_W-1:0] ret_lat,     // Load latency
    output logic [pes_pkg::PES_SRC_W-1:0] ret_src,     // Data source
    output logic [1:0] ret_active,                     // Retiring, per thread
    output logic [1:0] disp_any,                       // Any-port dispatch
    output logic [1:0] disp_alu                        // ALU-port dispatch
);
    import pes_pkg::*;
    // Idle pipeline, busy dispatch
    initial begin
        ret_valid = 1'b0;
        {ret_thread, ret_is_load, ret_is_store, ret_is_branch} = 4'h0;
        ret_next_ip = 32'h0;
        ret_regs = '0;
        ret_lat = 16'h0;
        ret_src = 4'h0;
        {ret_active, disp_any, disp_alu} = 6'h3f;
    end
    // One retirement held n edges; stale payload scrambled after release
    task automatic retire(input logic v, input logic thr, input logic [2:0] f,
            input logic [PES_IP_W-1:0] ip, input logic [PES_LAT_W-1:0] lat, input int n);
        @(posedge clk_sys);
        ret_valid <= v;
        {ret_thread, ret_is_load, ret_is_store, ret_is_branch} <= {thr, f};
        ret_next_ip <= ip;
        ret_regs <= {PES_REG_N{ip ^ 32'h5a5a0000}};
        ret_lat <= lat;
        ret_src <= lat[3:0];
        repeat (n) @(posedge clk_sys);
        ret_valid <= 1'b0;
        {ret_thread, ret_is_load, ret_is_store, ret_is_branch} <= ~{thr, f};
        ret_next_ip <= ~ip;
        ret_regs <= ~{PES_REG_N{ip ^ 32'h5a5a0000}};
        ret_lat <= ~lat;
        ret_src <= ~lat[3:0];
    endtask : retire
    // Idle dispatch and retirement for n edges
    task automatic stall(input logic [1:0] any, input logic [1:0] alu,
            input logic [1:0] act, input int n);
        @(posedge clk_sys);
        {disp_any, disp_alu, ret_active} <= {any, alu, act};
        repeat (n) @(posedge clk_sys);
        {disp_any, disp_alu, ret_active} <= 6'h3f;
    endtask : stall
endmodule : pes_ret_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench for the precise event sampler
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import pes_pkg::*;
    logic clk_sys, rstn, cfg_precise, cfg_edge, cfg_load, smp_rd_req;
    pes_event_e cfg_event;
    logic [PES_THR_W-1:0] cfg_thresh;
    logic [PES_LAT_W-1:0] cfg_lat_min, ret_lat, smp_lat;
    logic ret_valid, ret_thread, ret_is_load, ret_is_store, ret_is_branch;
    logic [PES_IP_W-1:0] ret_next_ip, smp_ip;
    logic [PES_REGS_W-1:0] ret_regs, smp_regs;
    logic [PES_SRC_W-1:0] ret_src, smp_src;
    logic [1:0] ret_active, disp_any, disp_alu;
    logic smp_valid, sample_done, monitor_overflow_interrupt, armed;
    logic [2:0] smp_count;
    logic [PES_CNT_W-1:0] cfg_preset, ev_value, core_stall_count, alu0, alu1, rst0, rst1;
    int err_count, num_checks;

    pes_ret_model rm (.clk_sys, .ret_valid, .ret_thread, .ret_is_load, .ret_is_store,
        .ret_is_branch, .ret_next_ip, .ret_regs, .ret_lat, .ret_src, .ret_active,
        .disp_any, .disp_alu);
    pes_sampler dut (.clk_sys, .rstn, .clk_en(1'b1), .cfg_precise, .cfg_event,
        .cfg_thread(1'b0), .cfg_thresh, .cfg_edge, .cfg_invert(1'b0), .cfg_lat_min,
        .cfg_load, .cfg_preset, .ret_valid, .ret_thread, .ret_is_load, .ret_is_store,
        .ret_is_branch, .ret_next_ip, .ret_regs, .ret_lat, .ret_src, .ret_active, .disp_any,
        .disp_alu, .smp_rd_req, .smp_valid, .smp_ip, .smp_regs, .smp_lat, .smp_src, .smp_count,
        .sample_done, .monitor_overflow_interrupt, .armed, .ev_value, .core_stall_count,
        .thread_alu_port_stall_count0(alu0), .thread_alu_port_stall_count1(alu1),
        .ret_stall_count0(rst0), .ret_stall_count1(rst1));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare tasks and verdict
    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_val(input string what, input logic [PES_REGS_W-1:0] exp,
            input logic [PES_REGS_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic give_verdict();
        $display("Checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Bus-free helpers: settle, preset, pop, arm, capture
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic preload(input logic [PES_CNT_W-1:0] v);
        @(posedge clk_sys);
        cfg_load <= 1'b1;
        cfg_preset <= v;
        step(1);
        cfg_load <= 1'b0;
        step(1);
    endtask : preload
    task automatic pop();
        @(posedge clk_sys);
        smp_rd_req <= 1'b1;
        @(posedge clk_sys);
        smp_rd_req <= 1'b0;
        step(0);
    endtask : pop
    task automatic pop_chk(input logic [PES_IP_W-1:0] ip, input logic [2:0] cnt);
        pop();
        chk_bit("smp_valid", 1'b1, smp_valid);
        chk_val("smp_ip", ip, smp_ip);
        chk_val("smp_regs", {PES_REG_N{ip ^ 32'h5a5a0000}}, smp_regs);
        chk_val("smp_lat", ip[15:0], smp_lat);
        chk_val("smp_src", ip[3:0], smp_src);
        chk_val("smp_count", cnt, smp_count);
    endtask : pop_chk
    task automatic arm(input logic exp, input logic [2:0] cnt);
        preload(32'hffffffff);
        rm.retire(1'b1, 1'b0, 3'b100, 32'h0, 16'h0, 1);
        step(2);
        chk_bit("armed", exp, armed);
        chk_val("smp_count", cnt, smp_count);
    endtask : arm
    task automatic capture(input logic [PES_IP_W-1:0] ip, input logic [2:0] cnt);
        rm.retire(1'b1, 1'b0, 3'b100, ip, ip[15:0], 1);
        step(0);
        chk_bit("sample_done", 1'b1, sample_done);
        chk_bit("armed", 1'b0, armed);
        chk_val("smp_count", cnt, smp_count);
        chk_bit("interrupt", cnt == 3'h4, monitor_overflow_interrupt);
    endtask : capture

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_arm_capture();
        arm(1'b0, 3'h0);
        @(posedge clk_sys);
        cfg_precise <= 1'b1;
        arm(1'b1, 3'h0);
        capture(32'h1004, 3'h1);
        rm.retire(1'b1, 1'b0, 3'b100, 32'h1008, 16'h8, 1);
        step(0);
        chk_bit("sample_done", 1'b0, sample_done);
        pop_chk(32'h1004, 3'h0);
        pop();
        chk_bit("smp_valid", 1'b0, smp_valid);
    endtask : t_arm_capture
    task automatic t_buffer_full();
        for (int i = 0; i < 4; i++) begin
            arm(1'b1, i[2:0]);
            capture(32'h2000 + 32'(i * 16), 3'(i + 1));
        end
        arm(1'b1, 3'h4);
        rm.retire(1'b1, 1'b0, 3'b100, 32'h3000, 16'h0, 1);
        step(0);
        chk_val("smp_count", 3'h4, smp_count);
        chk_bit("sample_done", 1'b0, sample_done);
        chk_bit("armed", 1'b1, armed);
        for (int i = 0; i < 4; i++) begin
            pop_chk(32'h2000 + 32'(i * 16), 3'(3 - i));
            chk_bit("interrupt", 1'b0, monitor_overflow_interrupt);
        end
    endtask : t_buffer_full
    task automatic t_events();
        logic [2:0] mflag [4] = '{3'b100, 3'b010, 3'b000, 3'b001};
        logic [2:0] nflag [4] = '{3'b010, 3'b100, 3'b000, 3'b100};
        @(posedge clk_sys);
        cfg_edge <= 1'b1;
        cfg_precise <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            cfg_event <= pes_event_e'(i);
            preload(32'h10);
            rm.retire(1'b0, 1'b0, mflag[i], 32'h0, 16'h0, 1);
            rm.retire(1'b1, 1'b1, mflag[i], 32'h0, 16'h0, 1);
            if (i != 2) rm.retire(1'b1, 1'b0, nflag[i], 32'h0, 16'h0, 1);
            rm.retire(1'b1, 1'b0, mflag[i], 32'h0, 16'h0, 2);
            step(1);
            chk_val("ev_value", 32'h12, ev_value);
        end
        @(posedge clk_sys);
        cfg_thresh <= 8'h1;
        preload(32'h0);
        rm.retire(1'b1, 1'b0, 3'b001, 32'h0, 16'h0, 2);
        step(1);
        chk_val("ev_value", 32'h1, ev_value);
        @(posedge clk_sys);
        cfg_thresh <= 8'h0;
        cfg_event <= PES_EV_LOAD_LAT;
        cfg_lat_min <= 16'h20;
        preload(32'h0);
        rm.retire(1'b1, 1'b0, 3'b100, 32'h0, 16'h1f, 1);
        rm.retire(1'b1, 1'b0, 3'b100, 32'h0, 16'h20, 1);
        step(1);
        chk_val("ev_value", 32'h1, ev_value);
    endtask : t_events
    task automatic t_stalls();
        @(posedge clk_sys);
        cfg_event <= PES_EV_RET_STALL;
        preload(32'h0);
        rm.stall(2'b10, 2'b11, 2'b11, 2);
        rm.stall(2'b00, 2'b10, 2'b10, 3);
        step(1);
        chk_val("core_stall", 32'h3, core_stall_count);
        chk_val("alu_stall0", 32'h3, alu0);
        chk_val("alu_stall1", 32'h0, alu1);
        chk_val("ret_stall0", 32'h3, rst0);
        chk_val("ret_stall1", 32'h0, rst1);
        chk_val("ev_value", 32'h3, ev_value);
    endtask : t_stalls

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rstn, cfg_precise, cfg_edge, cfg_load, smp_rd_req} = 5'h0;
        cfg_event = PES_EV_LOADS;
        cfg_lat_min = 16'h0;
        cfg_thresh = 8'h0;
        cfg_preset = 32'h0;
        err_count = 0;
        num_checks = 0;
        step(5);
        chk_val("reset_outs", '0, {ev_value, smp_count, armed, sample_done, smp_valid});
        @(posedge clk_sys);
        rstn <= 1'b1;
        t_arm_capture();
        t_buffer_full();
        t_events();
        t_stalls();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
